// File: rtl/tra_sync.v
// two-flop synchroniser for a bus of external inputs
`timescale 1ns/1ps
module tra_sync #(
	parameter WIDTH = 25
) (
	input wire core_clk,
	input wire sys_rst,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] stage1_reg;
	reg [WIDTH-1:0] stage2_reg;
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stage1_reg <= {WIDTH{1'b0}};
			stage2_reg <= {WIDTH{1'b0}};
		end else begin
			stage1_reg <= async_in;
			stage2_reg <= stage1_reg;
		end
	end
	assign sync_out = stage2_reg;
endmodule // tra_sync

// File: rtl/tra_top.v
// register access logic of a single-channel output terminal
// Functional notes
// - control bit 7 set marks the cycle as a register access
// - control bit 6 set means write, clear means read
// - control bits 5..0 give the register number 0..63
// - read receipt returns the control byte unchanged in status
// - write receipt returns the control byte with only bit 6 cleared
// - read places the addressed register contents in the inbound word
// - outbound word ignored on read, holds new value on write
// - frames are control or status byte, data high, data low
// - user registers reject writes while locked, code word always writable
// - writing the unlock value to the code word lifts protection
// - any other code word value reinstates protection
// - configuration writes only take effect after the next restart; here a restart reloads the defaults, so written values are lost
// - user switch-on selected drives user value after reset or watchdog
// - user scaling applied only while scaling enable is set
// - user gain comes up with its default after reset
// - register nine returns firmware revision as two ascii characters
// - watchdog runs only while watchdog enable is set, default set
// - without user select the manufacturer switch-on value is used
// - code word returns to locked on every restart
`timescale 1ns/1ps
`include "tra_regs.vh"
module tra_top #(
	parameter [15:0] FW_REVISION = 16'h5858, // arbitrary value
	parameter [15:0] MFR_ON_VALUE = 16'h0000,
	parameter WDOG_CYCLES = `TRA_WDOG_CYCLES
) (
	input wire core_clk,
	input wire sys_rst,
	input wire frame_strobe,
	input wire [7:0] out_byte0,
	input wire [7:0] out_byte1,
	input wire [7:0] out_byte2,
	input wire [15:0] process_output,
	output reg [7:0] in_byte0,
	output reg [7:0] in_byte1,
	output reg [7:0] in_byte2,
	output reg [15:0] channel_output,
	output reg user_scaling_active,
	output reg [15:0] active_scale_offset,
	output reg [15:0] active_scale_gain,
	output reg write_protect_active
);
	// ========================================
	// input synchronisation
	wire [24:0] sync_bus;
	wire frame_sync;
	wire [7:0] control_byte;
	wire [15:0] outbound_data_word;
	reg frame_prev_reg;
	tra_sync #(.WIDTH(25)) u_sync (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.async_in({frame_strobe, out_byte0, out_byte1, out_byte2}),
		.sync_out(sync_bus)
	);
	assign frame_sync = sync_bus[24];
	assign control_byte = sync_bus[23:16];
	// high byte first on the wire
	assign outbound_data_word = sync_bus[15:0];
	// process_output comes from same-clock logic, not synchronised
	wire frame_pulse;
	assign frame_pulse = frame_sync & ~frame_prev_reg;
	// ========================================
	// decode
	wire is_reg_access;
	wire is_write;
	wire [5:0] reg_addr;
	assign is_reg_access = control_byte[`TRA_CTL_REGACC_BIT];
	assign is_write = control_byte[`TRA_CTL_WRITE_BIT];
	assign reg_addr = control_byte[`TRA_CTL_ADDR_MSB:`TRA_CTL_ADDR_LSB];
	function is_user_reg;
		input [5:0] a;
		begin
			is_user_reg = (a >= `TRA_ADDR_USER_FIRST) && (a <= `TRA_ADDR_USER_ON_VALUE);
		end
	endfunction
	// ========================================
	// registers: stored values and restart-latched active copies
	reg [15:0] code_word_reg;
	reg [15:0] config_reg;
	reg [15:0] user_offset_reg;
	reg [15:0] user_gain_reg;
	reg [15:0] user_on_value_reg;
	reg [15:0] cfg_active_reg;
	reg [15:0] offset_active_reg;
	reg [15:0] gain_active_reg;
	reg [15:0] on_value_active_reg;
	reg [7:0] last_control_reg;
	reg access_done_reg;
	reg power_on_pending_reg;
	reg startup_reg;
	wire unlocked;
	wire new_access;
	wire write_ok;
	assign unlocked = (code_word_reg == `TRA_UNLOCK_VALUE);
	// one evaluation per access, not repeated on received cycles while the control byte is unchanged
	assign new_access = frame_pulse && is_reg_access
		&& (!access_done_reg || control_byte != last_control_reg);
	assign write_ok = new_access && is_write
		&& ((reg_addr == `TRA_ADDR_CODE_WORD) || (is_user_reg(reg_addr) && unlocked));
	// ========================================
	// register read mux
	function [15:0] read_mux;
		input [5:0] a;
		input [15:0] cw;
		input [15:0] cf;
		input [15:0] uo;
		input [15:0] ug;
		input [15:0] uv;
		begin
			case (a)
				`TRA_ADDR_FW_REV: read_mux = FW_REVISION;
				`TRA_ADDR_CODE_WORD: read_mux = cw;
				`TRA_ADDR_CONFIG: read_mux = cf;
				`TRA_ADDR_USER_OFFSET: read_mux = uo;
				`TRA_ADDR_USER_GAIN: read_mux = ug;
				`TRA_ADDR_USER_ON_VALUE: read_mux = uv;
				default: read_mux = 16'h0000;
			endcase
		end
	endfunction
	// ========================================
	// writes
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			code_word_reg <= `TRA_RST_CODE_WORD;
			config_reg <= `TRA_RST_CONFIG;
			user_offset_reg <= `TRA_RST_USER_OFFSET;
			user_gain_reg <= `TRA_RST_USER_GAIN;
			user_on_value_reg <= `TRA_RST_USER_ON_VALUE;
			frame_prev_reg <= 1'b0;
			last_control_reg <= 8'h00;
			access_done_reg <= 1'b0;
		end else begin
			frame_prev_reg <= frame_sync;
			if (frame_pulse) begin
				last_control_reg <= control_byte;
				access_done_reg <= is_reg_access;
			end
			// outbound word only used on a write
			if (write_ok) begin
				case (reg_addr)
					`TRA_ADDR_CODE_WORD: code_word_reg <= outbound_data_word;
					`TRA_ADDR_CONFIG: config_reg <= outbound_data_word;
					`TRA_ADDR_USER_OFFSET: user_offset_reg <= outbound_data_word;
					`TRA_ADDR_USER_GAIN: user_gain_reg <= outbound_data_word;
					`TRA_ADDR_USER_ON_VALUE: user_on_value_reg <= outbound_data_word;
					default: code_word_reg <= code_word_reg;
				endcase
			end
		end
	end
	// ========================================
	// active copies taken once after reset release
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			startup_reg <= 1'b1;
			cfg_active_reg <= `TRA_RST_CONFIG;
			offset_active_reg <= `TRA_RST_USER_OFFSET;
			gain_active_reg <= `TRA_RST_USER_GAIN;
			on_value_active_reg <= `TRA_RST_USER_ON_VALUE;
		end else begin
			startup_reg <= 1'b0;
			if (startup_reg) begin
				cfg_active_reg <= config_reg;
				offset_active_reg <= user_offset_reg;
				gain_active_reg <= user_gain_reg;
				on_value_active_reg <= user_on_value_reg;
			end
		end
	end
	// ========================================
	// watchdog
	wire wdog_expired;
	tra_wdog #(.TIMEOUT_CYCLES(WDOG_CYCLES)) u_wdog (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.enable(cfg_active_reg[`TRA_CFG_WDOG_EN_BIT]),
		.kick(frame_pulse),
		.expired_pulse(wdog_expired)
	);
	// ========================================
	// output value selection
	wire [15:0] switch_on_value;
	assign switch_on_value = cfg_active_reg[`TRA_CFG_USER_ON_BIT]
		? on_value_active_reg : MFR_ON_VALUE;
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			power_on_pending_reg <= 1'b1;
			channel_output <= 16'h0000;
			user_scaling_active <= 1'b0;
			active_scale_offset <= 16'h0000;
			active_scale_gain <= `TRA_RST_USER_GAIN;
			write_protect_active <= 1'b1;
		end else begin
			write_protect_active <= ~unlocked;
			user_scaling_active <= cfg_active_reg[`TRA_CFG_SCALE_EN_BIT];
			active_scale_offset <= offset_active_reg;
			active_scale_gain <= gain_active_reg;
			if (startup_reg) begin
				power_on_pending_reg <= 1'b1;
			end else if (wdog_expired) begin
				power_on_pending_reg <= 1'b1;
				channel_output <= switch_on_value;
			end else if (frame_pulse && !is_reg_access) begin
				power_on_pending_reg <= 1'b0;
				channel_output <= process_output;
			end else if (power_on_pending_reg) begin
				channel_output <= switch_on_value;
			end
		end
	end
	// ========================================
	// receipt and inbound word, held until the next new access or process data frame
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			in_byte0 <= 8'h00;
			in_byte1 <= 8'h00;
			in_byte2 <= 8'h00;
		end else if (new_access) begin
			if (is_write) begin
				in_byte0 <= control_byte & 8'hBF;
				// inbound word left as is, invalid after a write
			end else begin
				in_byte0 <= control_byte;
				{in_byte1, in_byte2} <= read_mux(reg_addr, code_word_reg, config_reg,
					user_offset_reg, user_gain_reg, user_on_value_reg);
			end
		end else if (frame_pulse && !is_reg_access) begin
			in_byte0 <= control_byte;
			{in_byte1, in_byte2} <= channel_output;
		end
	end
endmodule // tra_top

// File: rtl/tra_wdog.v
// process data watchdog: counts cycles since the last received frame
`timescale 1ns/1ps
`include "tra_regs.vh"
module tra_wdog #(
	parameter TIMEOUT_CYCLES = `TRA_WDOG_CYCLES
) (
	input wire core_clk,
	input wire sys_rst,
	input wire enable,
	input wire kick,
	output reg expired_pulse
);
	reg [31:0] count_reg;
	reg [31:0] count_next;
	reg expired_next;
	always @* begin
		count_next = count_reg;
		expired_next = 1'b0;
		if (!enable || kick) begin
			count_next = 32'h00000000;
		end else if (count_reg == TIMEOUT_CYCLES - 1) begin
			count_next = 32'h00000000;
			expired_next = 1'b1;
		end else begin
			count_next = count_reg + 32'h00000001;
		end
	end
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			count_reg <= 32'h00000000;
			expired_pulse <= 1'b0;
		end else begin
			count_reg <= count_next;
			expired_pulse <= expired_next;
		end
	end
endmodule // tra_wdog

// File: shared/tra_regs.vh
// register map, field positions, reset values and timing for terminal register access
`ifndef TRA_REGS_VH
`define TRA_REGS_VH
// ========================================
// control and status byte fields
`define TRA_CTL_REGACC_BIT 7
`define TRA_CTL_WRITE_BIT 6
`define TRA_CTL_ADDR_MSB 5
`define TRA_CTL_ADDR_LSB 0
// ========================================
// register numbers
`define TRA_ADDR_FW_REV 6'h09
`define TRA_ADDR_CODE_WORD 6'h1F
`define TRA_ADDR_CONFIG 6'h20
`define TRA_ADDR_USER_OFFSET 6'h21
`define TRA_ADDR_USER_GAIN 6'h22
`define TRA_ADDR_USER_ON_VALUE 6'h23
// first number of the user register range; the code word at this number stays writable while locked
`define TRA_ADDR_USER_FIRST 6'h1F
// ========================================
// configuration fields
`define TRA_CFG_SCALE_EN_BIT 0
`define TRA_CFG_WDOG_EN_BIT 2
`define TRA_CFG_USER_ON_BIT 8
// ========================================
// values
`define TRA_UNLOCK_VALUE 16'h1235
`define TRA_RST_CONFIG 16'h0006
`define TRA_RST_USER_GAIN 16'h0100
`define TRA_RST_USER_OFFSET 16'h0000
`define TRA_RST_USER_ON_VALUE 16'h0000
`define TRA_RST_CODE_WORD 16'h0000
// ========================================
// timing
`define TRA_WDOG_TIMEOUT_MS 100
`define TRA_CLK_HZ 50000000
`define TRA_WDOG_CYCLES ((`TRA_WDOG_TIMEOUT_MS * `TRA_CLK_HZ) / 1000)
`endif

// File: sim/terminal_register_access_tb_top.sv
// self-checking bench for terminal register access
`timescale 1ns/1ps
module terminal_register_access_tb_top;
	localparam [15:0] FW = 16'h4142; // arbitrary value
	localparam [15:0] MFR = 16'h0A5A;
	reg core_clk = 1'b0;
	reg sys_rst = 1'b1;
	wire stb, wp, scal;
	wire [7:0] ob0, ob1, ob2, ib0, ib1, ib2;
	wire [15:0] pv, ch, gain, offs;
	integer err_count = 0;
	integer check_count = 0;
	always #10 core_clk = ~core_clk;
	tra_coupler_model cpl (.core_clk(core_clk), .frame_strobe(stb), .out_byte0(ob0),
		.out_byte1(ob1), .out_byte2(ob2), .process_output(pv));
	tra_top #(.FW_REVISION(FW), .MFR_ON_VALUE(MFR), .WDOG_CYCLES(50)) dut (
		.core_clk(core_clk), .sys_rst(sys_rst), .frame_strobe(stb), .out_byte0(ob0),
		.out_byte1(ob1), .out_byte2(ob2), .process_output(pv), .in_byte0(ib0),
		.in_byte1(ib1), .in_byte2(ib2), .channel_output(ch), .user_scaling_active(scal),
		.active_scale_offset(offs), .active_scale_gain(gain), .write_protect_active(wp));
	// ========================================
	// shared tasks
	task chk(input string what, input [15:0] exp, input [15:0] got);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("FAIL %0s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	task rd(input [5:0] a, input [15:0] exp);
		begin
			cpl.xfer({2'b10, a}, 16'hFFFF, 16'h0000);
			chk("status", {10'h2, a}, {8'h0, ib0});
			chk("word", exp, {ib1, ib2});
		end
	endtask
	task wr(input [5:0] a, input [15:0] v);
		begin
			cpl.xfer({2'b11, a}, v, 16'h0000);
			chk("wstatus", {10'h2, a}, {8'h0, ib0}); // inbound word unused
		end
	endtask
	task wrap_up;
		begin
			$display("checks %0d errors %0d", check_count, err_count);
			if (err_count == 0 && check_count > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	// ========================================
	// scenarios
	task t_reset;
		begin
			chk("protect", 16'h1, {15'h0, wp});
			chk("act gain", 16'h0100, gain);
			chk("act offset", 16'h0000, offs);
			rd(6'h22, 16'h0100);
			rd(6'h20, 16'h0006);
			rd(6'h09, FW);
			wr(6'h22, 16'h1234);
			rd(6'h22, 16'h0100);
		end
	endtask
	task t_unlock;
		begin
			wr(6'h1F, 16'h1235);
			chk("protect", 16'h0, {15'h0, wp});
			rd(6'h1F, 16'h1235);
			wr(6'h22, 16'h0200);
			rd(6'h22, 16'h0200);
			wr(6'h20, 16'h0007);
			rd(6'h20, 16'h0007);
			chk("act gain", 16'h0100, gain);
			chk("scaling", 16'h0, {15'h0, scal});
			wr(6'h1F, 16'h0000);
			chk("protect", 16'h1, {15'h0, wp});
			wr(6'h22, 16'h0300);
			rd(6'h22, 16'h0200);
		end
	endtask
	task t_wdog;
		begin
			cpl.xfer(8'h05, 16'h0000, 16'h1357);
			chk("echo", 16'h0005, {8'h0, ib0});
			chk("in word", MFR, {ib1, ib2});
			chk("output", 16'h1357, ch);
			repeat (60) @(posedge core_clk);
			chk("switch-on", MFR, ch);
		end
	endtask
	task t_restart;
		begin
			wr(6'h1F, 16'h1235);
			@(posedge core_clk) #1;
			sys_rst = 1'b1;
			repeat (2) @(posedge core_clk);
			#1;
			sys_rst = 1'b0;
			chk("protect", 16'h1, {15'h0, wp});
			rd(6'h22, 16'h0100);
			chk("switch-on", MFR, ch);
		end
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		#1;
		sys_rst = 1'b0;
		t_reset;
		t_unlock;
		t_wdog;
		t_restart;
		wrap_up;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		err_count = err_count + 1;
		$display("FAIL run expected done seen hang");
		wrap_up;
	end
endmodule // terminal_register_access_tb_top

// File: sim/tra_coupler_model.sv
// coupler model sending one frame per xfer call
`timescale 1ns/1ps
module tra_coupler_model (
	input wire core_clk,
	output reg frame_strobe,
	output reg [7:0] out_byte0,
	output reg [7:0] out_byte1,
	output reg [7:0] out_byte2,
	output reg [15:0] process_output
);
	initial begin
		frame_strobe = 1'b0;
		{out_byte0, out_byte1, out_byte2, process_output} = 40'h0;
	end
	// ========================================
	// one frame, bytes settle before strobe
	task xfer(input [7:0] ctl, input [15:0] word, input [15:0] pv);
		begin
			@(posedge core_clk) #1;
			out_byte0 = ctl;
			{out_byte1, out_byte2} = word;
			process_output = pv;
			@(posedge core_clk) #1;
			frame_strobe = 1'b1;
			repeat (6) @(posedge core_clk);
			#1;
			frame_strobe = 1'b0;
			{out_byte0, out_byte1, out_byte2} = ~{ctl, word};
			repeat (4) @(posedge core_clk);
		end
	endtask
endmodule // tra_coupler_model

// File: sim/tra_top_assertions.sv
// port checker for terminal register access
`timescale 1ns/1ps
module tra_top_assertions #(
	parameter [15:0] FW_REVISION = 16'h5858
) (
	input wire core_clk,
	input wire sys_rst,
	input wire frame_strobe,
	input wire [7:0] out_byte0,
	input wire [7:0] out_byte1,
	input wire [7:0] out_byte2,
	input wire [15:0] process_output,
	input wire [7:0] in_byte0,
	input wire [7:0] in_byte1,
	input wire [7:0] in_byte2,
	input wire [15:0] channel_output,
	input wire user_scaling_active,
	input wire [15:0] active_scale_gain,
	input wire write_protect_active
);
	// ========================================
	// assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	reset_vals_a: assert property ($fell(sys_rst) |-> write_protect_active
		&& !user_scaling_active && active_scale_gain == 16'h0100) else $error("reset values");
	read_echo_a: assert property ($rose(frame_strobe) && out_byte0[7:6] == 2'b10
		|-> ##5 in_byte0 == $past(out_byte0, 5)) else $error("read receipt");
	write_echo_a: assert property ($rose(frame_strobe) && out_byte0[7:6] == 2'b11
		|-> ##5 in_byte0 == ($past(out_byte0, 5) & 8'hBF)) else $error("write receipt");
	fw_read_a: assert property ($rose(frame_strobe) && out_byte0 == 8'h89
		|-> ##5 {in_byte1, in_byte2} == FW_REVISION) else $error("revision word");
	unlock_a: assert property ($rose(frame_strobe) && out_byte0 == 8'hDF
		&& {out_byte1, out_byte2} == 16'h1235 |-> ##6 !write_protect_active) else $error("unlock");
	relock_a: assert property ($rose(frame_strobe) && out_byte0 == 8'hDF
		&& {out_byte1, out_byte2} != 16'h1235 |-> ##6 write_protect_active) else $error("relock");
	protect_hold_a: assert property (!frame_strobe [*6] |=> $stable(write_protect_active))
		else $error("protect changed");
	normal_out_a: assert property ($rose(frame_strobe) && !out_byte0[7]
		|-> ##5 channel_output == $past(process_output, 5)) else $error("output word");
endmodule // tra_top_assertions
bind tra_top tra_top_assertions #(.FW_REVISION(FW_REVISION)) u_chk (.core_clk(core_clk),
	.sys_rst(sys_rst), .frame_strobe(frame_strobe), .out_byte0(out_byte0),
	.out_byte1(out_byte1), .out_byte2(out_byte2), .process_output(process_output),
	.in_byte0(in_byte0), .in_byte1(in_byte1), .in_byte2(in_byte2),
	.channel_output(channel_output), .user_scaling_active(user_scaling_active),
	.active_scale_gain(active_scale_gain), .write_protect_active(write_protect_active));
